//--- spisbc_pkg.sv
// package: constants and types of the serial shift and buffer core
package spisbc_pkg;

    localparam int unsigned SPISBC_BYTE_W       = 8;
    localparam int unsigned SPISBC_HALF_DEFAULT = 8;
    localparam logic [4:0]  SPISBC_LAST_EDGE    = 5'h10;
    localparam logic [2:0]  SPISBC_LAST_BIT     = 3'h7;
    localparam logic [7:0]  SPISBC_BYTE_RST     = 8'h00;
    localparam logic        SPISBC_FLAG_TX_RST  = 1'b1;
    localparam logic        SPISBC_FLAG_RX_RST  = 1'b0;
    localparam logic [2:0]  SPISBC_SYNC_RST     = 3'h7;

    typedef enum logic [1:0] {
        SPISBC_IDLE = 2'b00,
        SPISBC_RUN  = 2'b01,
        SPISBC_TAIL = 2'b10
    } spisbc_state_type;

    typedef struct packed {
        logic clock_polarity_sel;
        logic clock_phase_sel;
        logic lsb;
    } spisbc_cfg_type;

    typedef struct packed {
        spisbc_state_type st;
        logic [7:0]       half;
        logic [4:0]       edges;
        logic [3:0]       bitn;
        logic             sck;
        logic             mosi;
        logic             ssn;
        logic             drv;
        logic             miso_oe;
        logic             busy;
        logic [7:0]       tx_hold;
        logic             tx_empty;
        logic [7:0]       rx_buf;
        logic             rx_full;
        logic [7:0]       sh_tx;
        logic [7:0]       sh_rx;
        logic [7:0]       slv_tx;
        logic             slv_loaded;
        logic [2:0]       miso_s;
        logic             miso_f;
        logic [2:0]       ssn_s;
        logic             ss_act;
        logic [2:0]       tgl_s;
        logic             tgl_seen;
    } spisbc_core_type;

    typedef struct packed {
        logic [7:0] rx;
        logic [7:0] rxq;
        logic       tgl;
    } spisbc_link_type;

    // bit of the byte that goes on the line after cnt bits are done
    function automatic logic [2:0] spisbc_bidx(input logic [2:0] cnt,
                                               input logic       lsb);
        return lsb ? cnt : (SPISBC_LAST_BIT - cnt);
    endfunction

endpackage

//--- spisbc_slave_link.sv
// module: slave shifter that runs on the serial clock from the remote master
`timescale 1ns/1ps
module spisbc_slave_link (
    // link clock and frame
    input  wire logic                     link_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ss_n_i,
    input  wire spisbc_pkg::spisbc_cfg_type cfg_i,
    // serial data
    input  wire logic                     din_i,
    output logic                          dout_o,
    // core side, stable across a byte
    input  wire logic [7:0]               tx_byte_i,
    output logic [7:0]                    rx_byte_o,
    output logic                          done_tgl_o
);
    import spisbc_pkg::*;

    spisbc_link_type r, n;
    logic [2:0]      cnt_r;
    logic            out_r;

    // rising edge of link_clk_i is always the sampling edge
    always_comb begin
        n = r;
        if (cfg_i.lsb) begin
            n.rx = {din_i, r.rx[7:1]};
        end else begin
            n.rx = {r.rx[6:0], din_i};
        end
        if (cnt_r == SPISBC_LAST_BIT) begin
            n.rxq = n.rx;
            n.tgl = ~r.tgl;
        end
    end

    // core reset clears it, so the toggle starts where the core's copy does
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (!ss_n_i) begin
            r <= n;
        end
    end

    // select high clears the bit count, so a frame always starts aligned
    always_ff @(posedge link_clk_i or posedge ss_n_i) begin
        if (ss_n_i) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // output changes half a clock after each sample
    always_ff @(negedge link_clk_i or posedge ss_n_i) begin
        if (ss_n_i) begin
            out_r <= 1'b0;
        end else begin
            out_r <= tx_byte_i[spisbc_bidx(cnt_r, cfg_i.lsb)];
        end
    end

    // phase 0 needs the first bit before any clock edge
    assign dout_o     = (!cfg_i.clock_phase_sel && cnt_r == 3'h0)
                        ? tx_byte_i[spisbc_bidx(3'h0, cfg_i.lsb)] : out_r;
    assign rx_byte_o  = r.rxq;
    assign done_tgl_o = r.tgl;

endmodule // spisbc_slave_link

//--- spisbc_core.sv
// module: double buffered serial shift engine, master and slave
//
// Operation
// - bytes go most significant bit first, least first when selected
// - phase 1 slave: back to back bytes with select held low
// - one byte waits for transmit, one received byte is held
// - transmit empty flag high while the holding buffer can take a byte
// - receive full flag high while a received byte waits
// - overrun keeps the old byte, drops the new, flags nothing
// - polarity control inverts the serial clock for all transfers
// - phase control picks one of two clock to data relations
// - phase 1: first bit at first edge, last ends after sixteenth
// - slave samples master-out line, master samples master-in line
// - master write when empty starts; byte moves to shifter, empty set
// - sample on one edge, shift half later; after eight, byte to buffer
// - waiting byte at transfer end loads at once and next transfer runs
`timescale 1ns/1ps
module spisbc_core #(
    parameter int unsigned HALF_CYC = spisbc_pkg::SPISBC_HALF_DEFAULT
) (
    // clock and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    // configuration
    input  wire logic       MASTER_MODE_I,
    input  wire logic       CLOCK_POLARITY_SEL_I,
    input  wire logic       CLOCK_PHASE_SEL_I,
    input  wire logic       LSB_FIRST_SELECT_I,
    // data register side
    input  wire logic       DATA_WR_I,
    input  wire logic [7:0] DATA_WR_BYTE_I,
    input  wire logic       DATA_RD_I,
    output logic [7:0]      RX_DATA_O,
    output logic            TX_BUFFER_EMPTY_FLAG_O,
    output logic            RX_BUFFER_FULL_FLAG_O,
    output logic            BUSY_O,
    // serial clock line
    input  wire logic       SERIAL_CLOCK_LINE_I,
    output logic            SERIAL_CLOCK_LINE_O,
    output logic            SERIAL_CLOCK_LINE_OE_O,
    // master out line
    input  wire logic       MOSI_I,
    output logic            MOSI_O,
    output logic            MOSI_OE_O,
    // master in line
    input  wire logic       MISO_I,
    output logic            MISO_O,
    output logic            MISO_OE_O,
    // slave select, active low
    input  wire logic       SS_N_I,
    output logic            SS_N_O,
    output logic            SS_N_OE_O
);
    import spisbc_pkg::*;

    spisbc_core_type r, n;
    spisbc_cfg_type  cfg;
    logic            link_clk;
    logic [7:0]      link_rx;
    logic            link_tgl;
    logic            half_end;
    logic            smp;
    logic [4:0]      edge_n;
    logic            done_m;
    logic            done_s;
    logic            rx_done;
    logic [7:0]      rxb;
    logic            start;
    logic            first_bit;
    logic [7:0]      shin;

    assign cfg = '{clock_polarity_sel: CLOCK_POLARITY_SEL_I, clock_phase_sel: CLOCK_PHASE_SEL_I,
                   lsb: LSB_FIRST_SELECT_I};
    // sampling edge is rising after inversion by polarity and phase
    assign link_clk = SERIAL_CLOCK_LINE_I ^ cfg.clock_polarity_sel ^ cfg.clock_phase_sel;

    spisbc_slave_link u_link (
        .link_clk_i (link_clk),
        .rst_i      (SYS_RST_I),
        .ss_n_i     (SS_N_I),
        .cfg_i      (cfg),
        .din_i      (MOSI_I),
        .dout_o     (MISO_O),
        .tx_byte_i  (r.slv_tx),
        .rx_byte_o  (link_rx),
        .done_tgl_o (link_tgl)
    );

    always_comb begin
        n         = r;
        half_end  = (r.half == 8'(HALF_CYC - 1));
        smp       = 1'b0;
        edge_n    = r.edges + 5'h1;
        done_m    = 1'b0;
        start     = 1'b0;
        first_bit = r.tx_hold[spisbc_bidx(3'h0, cfg.lsb)];
        // master samples the filtered master-in line
        shin = cfg.lsb ? {r.miso_f, r.sh_rx[7:1]}
                       : {r.sh_rx[6:0], r.miso_f};
        // pins pass three flops; a change counts once two and three agree
        n.miso_s = {r.miso_s[1:0], MISO_I};
        n.ssn_s  = {r.ssn_s[1:0], SS_N_I};
        n.tgl_s  = {r.tgl_s[1:0], link_tgl};
        if (r.miso_s[1] == r.miso_s[2]) begin
            n.miso_f = r.miso_s[2];
        end
        if (r.ssn_s[1] == r.ssn_s[2]) begin
            n.ss_act = ~r.ssn_s[2];
        end
        done_s = (r.tgl_s[1] == r.tgl_s[2]) && (r.tgl_s[2] != r.tgl_seen)
                 && !MASTER_MODE_I;
        if (r.tgl_s[1] == r.tgl_s[2]) begin
            n.tgl_seen = r.tgl_s[2];
        end
        // master shifter, clock made here by a divider
        case (r.st)
            SPISBC_IDLE: begin
                n.sck = cfg.clock_polarity_sel;
                n.ssn = 1'b1;
            end
            SPISBC_RUN: begin
                if (half_end) begin
                    n.half  = 8'h00;
                    n.sck   = ~r.sck;
                    n.edges = edge_n;
                    smp     = cfg.clock_phase_sel ^ edge_n[0];
                    if (smp) begin
                        n.sh_rx = shin;
                        n.bitn  = r.bitn + 4'h1;
                    end else begin
                        n.mosi = r.sh_tx[spisbc_bidx(r.bitn[2:0], cfg.lsb)];
                    end
                    if (edge_n == SPISBC_LAST_EDGE) begin
                        n.st = SPISBC_TAIL;
                    end
                end else begin
                    n.half = r.half + 8'h01;
                end
            end
            SPISBC_TAIL: begin
                // last bit ends half a clock after the sixteenth edge
                if (half_end) begin
                    done_m = 1'b1;
                    n.half = 8'h00;
                    n.ssn  = 1'b1;
                    n.st   = SPISBC_IDLE;
                end else begin
                    n.half = r.half + 8'h01;
                end
            end
            default: begin
                n.st = SPISBC_IDLE;
            end
        endcase
        // transmit holding buffer
        if (DATA_WR_I && r.tx_empty) begin
            n.tx_hold  = DATA_WR_BYTE_I;
            n.tx_empty = 1'b0;
        end
        if (MASTER_MODE_I && !r.tx_empty && (r.st == SPISBC_IDLE || done_m))
        begin
            start      = 1'b1;
            n.tx_empty = 1'b1;
            n.sh_tx    = r.tx_hold;
            n.st       = SPISBC_RUN;
            n.half     = 8'h00;
            n.edges    = 5'h00;
            n.bitn     = 4'h0;
            n.ssn      = 1'b0;
            n.mosi     = first_bit;
        end
        // slave: the shifter byte only changes between bytes
        if (!MASTER_MODE_I && ((!r.ss_act && !r.slv_loaded) || done_s)) begin
            n.slv_loaded = 1'b0;
            if (!r.tx_empty) begin
                n.slv_tx     = r.tx_hold;
                n.tx_empty   = 1'b1;
                n.slv_loaded = 1'b1;
            end
        end
        // receive holding buffer; a new byte beats a read in the same cycle
        rx_done = done_m || done_s;
        rxb     = done_m ? r.sh_rx : link_rx;
        if (DATA_RD_I) begin
            n.rx_full = 1'b0;
        end
        if (rx_done && (!r.rx_full || DATA_RD_I)) begin
            n.rx_buf  = rxb;
            n.rx_full = 1'b1;
        end
        n.drv     = MASTER_MODE_I;
        n.miso_oe = !MASTER_MODE_I && r.ss_act;
        n.busy    = (n.st != SPISBC_IDLE) || n.miso_oe;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            r            <= '0;
            r.st         <= SPISBC_IDLE;
            r.ssn        <= 1'b1;
            r.tx_empty   <= SPISBC_FLAG_TX_RST;
            r.rx_full    <= SPISBC_FLAG_RX_RST;
            r.rx_buf     <= SPISBC_BYTE_RST;
            r.ssn_s      <= SPISBC_SYNC_RST;
        end else begin
            r <= n;
        end
    end

    assign RX_DATA_O              = r.rx_buf;
    assign TX_BUFFER_EMPTY_FLAG_O = r.tx_empty;
    assign RX_BUFFER_FULL_FLAG_O  = r.rx_full;
    assign BUSY_O                 = r.busy;
    assign SERIAL_CLOCK_LINE_O    = r.sck;
    assign SERIAL_CLOCK_LINE_OE_O = r.drv;
    assign MOSI_O                 = r.mosi;
    assign MOSI_OE_O              = r.drv;
    assign MISO_OE_O              = r.miso_oe;
    assign SS_N_O                 = r.ssn;
    assign SS_N_OE_O              = r.drv;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_start;
        start;
    endsequence

    sequence s_accept;
        rx_done && !r.rx_full;
    endsequence

    a_rx_full_set: assert property (s_accept |=> RX_BUFFER_FULL_FLAG_O
        && RX_DATA_O == $past(rxb))
        else $error("received byte not placed in buffer");

    a_overrun_drop: assert property (
        rx_done && r.rx_full && !DATA_RD_I |=> $stable(RX_DATA_O)
        && RX_BUFFER_FULL_FLAG_O)
        else $error("overrun replaced the held byte");

    a_tx_load_empty: assert property (s_start |=> TX_BUFFER_EMPTY_FLAG_O
        && r.st == SPISBC_RUN)
        else $error("load did not free the transmit buffer");

    a_tx_wr_take: assert property (
        DATA_WR_I && TX_BUFFER_EMPTY_FLAG_O |=> !TX_BUFFER_EMPTY_FLAG_O
        && r.tx_hold == $past(DATA_WR_BYTE_I))
        else $error("write to empty transmit buffer lost");

    a_sck_idle: assert property (
        r.st == SPISBC_IDLE && $past(r.st) == SPISBC_IDLE
        |-> SERIAL_CLOCK_LINE_O == $past(CLOCK_POLARITY_SEL_I))
        else $error("serial clock not at idle level");

    a_back_to_back: assert property (
        done_m && !r.tx_empty && MASTER_MODE_I |=> r.st == SPISBC_RUN
        ##1 r.edges == 5'h00)
        else $error("waiting byte did not start at once");

    a_first_bit: assert property (
        (s_start and !CLOCK_PHASE_SEL_I) |=> MOSI_O == $past(first_bit))
        else $error("wrong first bit for bit order");

    a_edge_count: assert property (done_m |-> r.edges == SPISBC_LAST_EDGE
        && r.bitn == 4'h8)
        else $error("transfer ended without sixteen edges");

endmodule // spisbc_core

//--- spisbc_remote.sv
// remote serial peer: slave when the core masters, master otherwise
`timescale 1ns/1ps
module spisbc_remote (
    // configuration
    input  wire logic clock_polarity_sel_i,
    input  wire logic clock_phase_sel_i,
    input  wire logic lsb_i,
    input  wire logic slv_en_i,
    // serial lines seen on the wires
    input  wire logic sck_i,
    input  wire logic mosi_i,
    input  wire logic miso_i,
    input  wire logic ss_n_i,
    // lines driven by this peer
    output logic      sck_o,
    output logic      mosi_o,
    output logic      miso_o,
    output logic      ss_n_o
);
    logic [7:0] sq[$];
    logic [7:0] rq[$];
    logic [7:0] tx;
    logic [7:0] rx;
    logic       q;
    int         n;
    wire        e = sck_i ^ clock_polarity_sel_i ^ clock_phase_sel_i;
    // released line shows the inverse of its last bit
    assign miso_o = ss_n_i ? ~q : q;
    function automatic logic [2:0] ix(input int k);
        return lsb_i ? k[2:0] : 3'h7 - k[2:0];
    endfunction
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
        q = 1'b0;
        n = 0;
        tx = 8'h00;
    end
    always @(negedge ss_n_i) if (slv_en_i) begin
        n = 0;
        tx = sq.size() > 0 ? sq.pop_front() : 8'hA5;
        if (!clock_phase_sel_i) q = tx[ix(0)];
    end
    always @(posedge e) if (slv_en_i && !ss_n_i) begin
        rx[ix(n)] = mosi_i;
        n = n + 1;
        if (n == 8) begin
            rq.push_back(rx);
            n = 0;
            tx = sq.size() > 0 ? sq.pop_front() : 8'h5A;
        end
    end
    always @(negedge e) if (slv_en_i && !ss_n_i) q = tx[ix(n)];
    // one byte as master; keep leaves select low for the next byte
    task automatic xfer(input logic [7:0] b, input bit keep,
                        output logic [7:0] r);
        if (ss_n_o) begin
            sck_o = clock_polarity_sel_i;
            #64;
            ss_n_o = 1'b0;
            #64;
        end
        for (int i = 0; i < 8; i++) begin
            if (!clock_phase_sel_i) mosi_o = b[ix(i)];
            #32;
            if (!clock_phase_sel_i) r[ix(i)] = miso_i;
            sck_o = ~sck_o;
            if (clock_phase_sel_i) mosi_o = b[ix(i)];
            #32;
            if (clock_phase_sel_i) r[ix(i)] = miso_i;
            sck_o = ~sck_o;
        end
        #32;
        mosi_o = ~mosi_o;
        if (!keep) ss_n_o = 1'b1;
    endtask
endmodule // spisbc_remote

//--- tb_spisbc_core.sv
// self-checking bench of the serial shift and buffer core
`timescale 1ns/1ps
module tb_spisbc_core;
    import spisbc_pkg::*;
    logic        clk, rst, mm, clock_polarity_sel, clock_phase_sel, lsb, wr, rd;
    logic [7:0]  wb, rxd, a, b, r0, r1, x;
    logic        tx_e, rx_f, busy, sck_o, sck_oe, mosi_o, mosi_oe;
    logic        miso_o, miso_oe, ss_o, ss_oe;
    logic        r_sck, r_mosi, r_miso, r_ss;
    logic [15:0] seed;
    int          mismatches, n_checks;
    wire sck_w  = sck_oe ? sck_o : r_sck;
    wire mosi_w = mosi_oe ? mosi_o : r_mosi;
    wire miso_w = miso_oe ? miso_o : r_miso;
    wire ss_w   = ss_oe ? ss_o : r_ss;
    // short half period keeps runs brief, still above the sync latency
    spisbc_core #(.HALF_CYC(5)) spisbc_core_inst (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .MASTER_MODE_I(mm),
        .CLOCK_POLARITY_SEL_I(clock_polarity_sel), .CLOCK_PHASE_SEL_I(clock_phase_sel),
        .LSB_FIRST_SELECT_I(lsb), .DATA_WR_I(wr), .DATA_WR_BYTE_I(wb),
        .DATA_RD_I(rd), .RX_DATA_O(rxd), .TX_BUFFER_EMPTY_FLAG_O(tx_e),
        .RX_BUFFER_FULL_FLAG_O(rx_f), .BUSY_O(busy),
        .SERIAL_CLOCK_LINE_I(sck_w), .SERIAL_CLOCK_LINE_O(sck_o),
        .SERIAL_CLOCK_LINE_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
        .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
        .MISO_OE_O(miso_oe), .SS_N_I(ss_w), .SS_N_O(ss_o),
        .SS_N_OE_O(ss_oe));
    spisbc_remote spisbc_remote_inst (
        .clock_polarity_sel_i(clock_polarity_sel), .clock_phase_sel_i(clock_phase_sel), .lsb_i(lsb), .slv_en_i(mm),
        .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_w),
        .sck_o(r_sck), .mosi_o(r_mosi), .miso_o(r_miso), .ss_n_o(r_ss));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask
    task automatic wr_byte(input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        wb <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_byte;
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // bounded wait: full flag, or end of activity
    task automatic hold(input bit idle);
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            #1;
            if (idle ? busy === 1'b0 : rx_f === 1'b1) return;
        end
        mismatches++;
        $display("[FAIL] %0t wait ran out", $time);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    initial begin
        {rst, mm, clock_polarity_sel, clock_phase_sel, lsb, wr, rd} = 7'h60;
        wb = 8'h00;
        seed = 16'h7CCA;
        mismatches = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({5'h00, ss_o, tx_e, rx_f}, 8'h06);
        chk(rxd, 8'h00);
        // master: queued byte runs back to back, second reply overruns
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            {clock_polarity_sel, clock_phase_sel, lsb} <= m[2:0];
            rnd(a);
            rnd(b);
            rnd(r0);
            rnd(r1);
            if (m == 0) a = 8'h01;
            spisbc_remote_inst.sq.push_back(r0);
            spisbc_remote_inst.sq.push_back(r1);
            wr_byte(a);
            repeat (4) @(posedge clk);
            #1;
            chk({6'h00, tx_e, rx_f}, 8'h02);
            wr_byte(b);
            @(posedge clk);
            #1;
            chk({6'h00, tx_e, rx_f}, 8'h00);
            hold(1'b0);
            @(posedge clk);
            #1;
            chk({5'h00, busy, tx_e, rx_f}, 8'h07);
            hold(1'b1);
            chk(rxd, r0);
            chk({4'h0, sck_o, ss_o, tx_e, rx_f}, {4'h0, clock_polarity_sel, 3'h7});
            rd_byte();
            @(posedge clk);
            #1;
            chk({7'h00, rx_f}, 8'h00);
            chk(8'(spisbc_remote_inst.rq.size()), 8'h02);
            chk(spisbc_remote_inst.rq.pop_front(), a);
            chk(spisbc_remote_inst.rq.pop_front(), b);
        end
        // slave: phase 1 runs two bytes under one select
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            mm <= 1'b0;
            {clock_polarity_sel, clock_phase_sel, lsb} <= {seed[0], m[0], m[1]};
            rnd(a);
            rnd(b);
            rnd(r0);
            rnd(r1);
            wr_byte(a);
            if (m[0]) wr_byte(b);
            repeat (4) @(posedge clk);
            spisbc_remote_inst.xfer(r0, m[0], x);
            hold(1'b0);
            chk(rxd, r0);
            chk(x, a);
            rd_byte();
            if (m[0]) begin
                spisbc_remote_inst.xfer(r1, 1'b0, x);
                hold(1'b0);
                chk(rxd, r1);
                chk(x, b);
                rd_byte();
            end
            @(posedge clk);
            mm <= 1'b1;
        end
        repeat (4) @(posedge clk);
        summarize();
    end
endmodule // tb_spisbc_core
